// ===== logic/lie_cfg.svh
// Constants for the load instruction execution block.
`ifndef LIE_CFG_SVH
`define LIE_CFG_SVH
// Opcode field bounds: eight upper bits for most of the group, seven for the index loads.
`define LIE_OPC_MSB 15
`define LIE_OPC8_LSB 8
`define LIE_OPC7_LSB 9
// Opcode values of the group; the index loads match seven bits so bit 8 stays free as the register selector.
`define LIE_OP_ACC_IMM 8'h7E
`define LIE_OP_IDX_IMM 7'h38
`define LIE_OP_IDX_MEM 7'h1C
`define LIE_OP_IDX_SEL 16'h6880
`define LIE_OP_IDX_SEL_MASK 16'hFFFE
`define LIE_OP_PAGE_MEM 8'h6F
`define LIE_OP_PAGE_IMM 16'h6E00
`define LIE_OP_PAGE_IMM_MASK 16'hFFFE
`define LIE_OP_STAT_LOAD 8'h7B
`define LIE_OP_STAT_STORE 8'h7C
`define LIE_OP_MULT 8'h6A
`define LIE_OP_MULT_ACC 8'h6C
`define LIE_OP_MULT_MOVE 8'h6B
// Operand fields of the instruction word.
`define LIE_F_LOW 0
`define LIE_F_NEXT_VAL 0
`define LIE_F_NEXT_EN 3
`define LIE_F_DMA_MSB 6
`define LIE_F_IND 7
`define LIE_F_CONST_MSB 7
`define LIE_F_SEL 8
`define LIE_ADDR_MSB 7
// Status word bit positions and the fixed pattern of ones.
`define LIE_SW_WRAP 15
`define LIE_SW_SAT 14
`define LIE_SW_MASK 13
`define LIE_SW_PTR 8
`define LIE_SW_PAGE 0
`define LIE_SW_ONES 16'h1EFC
`define LIE_STORE_PAGE 1'b1
`define LIE_MOVE_STEP 8'h01
`endif

// ===== logic/lie_pkg.sv
// Types for the load instruction execution block.
package lie_pkg;
	typedef struct packed {
		logic wrap;
		logic sat;
		logic mask;
		logic ptr;
		logic page;
	} lie_status_t;
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [15:0] data;
	} lie_dwrite_t;
	typedef enum logic [2:0] {LIE_IDLE, LIE_READ, LIE_MOVE} lie_state_t;
endpackage : lie_pkg

// ===== logic/lie_exec.sv
// Execute stage for the load instruction group of the signal processor core.
`timescale 1ns/1ns
`include "lie_cfg.svh"

// What this block does
// [RQ1] Immediate accumulator load puts 8-bit constant positive into accumulator; PC advances one.
// [RQ2] Immediate index load writes constant right-aligned, zero-filled, never sign-extended.
// [RQ3] Immediate index load takes 0..255 and a one-bit index register selector.
// [RQ4] Status load copies memory word into wrap, saturate, pointer and page bits.
// [RQ5] Status load leaves the interrupt mask bit unchanged.
// [RQ6] Saved status layout: wrap 15, sat 14, mask 13, ptr 8, page 0, fixed ones.
// [RQ7] Direct status store always writes into data page 1.
// [RQ8] Direct status load reads the page chosen by the current page pointer.
// [RQ9] Status load uses 7-bit direct address; indirect may set next pointer 0 or 1.
// [RQ10] Memory index load copies word; page loads set pointer from LSB or constant.
// [RQ11] Multiplicand load; accumulate variant adds product; move variant copies upward.
module lie_exec
	import lie_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [15:0] i_dmem_rdata,
	input wire logic [31:0] i_product,
	input wire logic [15:0] i_index_addr,
	input wire logic i_irq_mask,
	output logic o_busy,
	output logic o_pc_inc,
	output logic [7:0] o_dmem_raddr,
	output lie_dwrite_t o_dmem_write,
	output logic [31:0] o_accum,
	output logic [15:0] o_index0,
	output logic [15:0] o_index1,
	output logic [15:0] o_multiplicand,
	output lie_status_t o_status,
	output logic [15:0] o_status_word
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	lie_state_t state_reg;
	logic [15:0] instr_reg;
	logic [31:0] accum_reg;
	logic [15:0] index_reg [2];
	logic [15:0] mult_reg;
	lie_status_t status_reg;
	lie_dwrite_t dwrite_reg;
	logic pc_inc_reg;
	logic [7:0] raddr_reg;

	// Upper opcode byte; most of the group is decoded from it alone.
	function automatic logic [7:0] lie_op8(input logic [15:0] ins);
		lie_op8 = ins[`LIE_OPC_MSB:`LIE_OPC8_LSB];
	endfunction : lie_op8

	// Upper seven opcode bits; the index loads keep their register selector just below them.
	function automatic logic [6:0] lie_op7(input logic [15:0] ins);
		lie_op7 = ins[`LIE_OPC_MSB:`LIE_OPC7_LSB];
	endfunction : lie_op7

	// Effective data address: direct uses page and 7-bit offset, indirect uses the pointed index.
	function automatic logic [7:0] lie_eff_addr(input logic [15:0] ins, input logic page, input logic [15:0] ix);
		lie_eff_addr = ins[`LIE_F_IND] ? ix[`LIE_ADDR_MSB:`LIE_F_LOW]
			: {page, ins[`LIE_F_DMA_MSB:`LIE_F_LOW]}; // RQ8 RQ9
	endfunction : lie_eff_addr

	// True when the opcode needs a data memory read before it completes.
	function automatic logic lie_needs_read(input logic [15:0] ins);
		lie_needs_read = (lie_op7(ins) == `LIE_OP_IDX_MEM) || (lie_op8(ins) == `LIE_OP_PAGE_MEM)
			|| (lie_op8(ins) == `LIE_OP_STAT_LOAD) || (lie_op8(ins) == `LIE_OP_MULT)
			|| (lie_op8(ins) == `LIE_OP_MULT_ACC) || (lie_op8(ins) == `LIE_OP_MULT_MOVE);
	endfunction : lie_needs_read

	logic [15:0] cur_index;
	logic [15:0] saved_word;
	assign cur_index = index_reg[status_reg.ptr];
	// Fixed ones and the zero at bit 1 come from the constant mask.
	assign saved_word = `LIE_SW_ONES | ({15'h0000, status_reg.wrap} << `LIE_SW_WRAP)
		| ({15'h0000, status_reg.sat} << `LIE_SW_SAT) | ({15'h0000, status_reg.mask} << `LIE_SW_MASK)
		| ({15'h0000, status_reg.ptr} << `LIE_SW_PTR) | ({15'h0000, status_reg.page} << `LIE_SW_PAGE); // RQ6

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// A read instruction takes one extra cycle, the move variant two, so the memory word is stable when consumed.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= LIE_IDLE;
			instr_reg <= 16'h0000;
			raddr_reg <= 8'h00;
		end else begin
			case (state_reg)
				LIE_IDLE: begin
					if (i_instr_valid && lie_needs_read(i_instr)) begin
						state_reg <= LIE_READ;
						instr_reg <= i_instr;
						raddr_reg <= lie_eff_addr(i_instr, status_reg.page, cur_index);
					end
				end
				LIE_READ: begin
					state_reg <= (lie_op8(instr_reg) == `LIE_OP_MULT_MOVE) ? LIE_MOVE : LIE_IDLE;
				end
				LIE_MOVE: begin
					state_reg <= LIE_IDLE;
				end
				default: begin
					state_reg <= LIE_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Program counter advance
	// ------------------------------------------------------------
	// Each instruction of this group is one word, so the counter advances once on completion.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pc_inc_reg <= 1'b0;
		end else begin
			pc_inc_reg <= (state_reg == LIE_IDLE && i_instr_valid && !lie_needs_read(i_instr))
				|| (state_reg == LIE_READ && lie_op8(instr_reg) != `LIE_OP_MULT_MOVE)
				|| (state_reg == LIE_MOVE); // RQ1
		end
	end

	// ------------------------------------------------------------
	// Accumulator
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			accum_reg <= 32'h0000_0000;
		end else if (state_reg == LIE_IDLE && i_instr_valid && lie_op8(i_instr) == `LIE_OP_ACC_IMM) begin
			accum_reg <= {24'h00_0000, i_instr[`LIE_F_CONST_MSB:`LIE_F_LOW]}; // RQ1
		end else if (state_reg == LIE_READ && (lie_op8(instr_reg) == `LIE_OP_MULT_ACC
			|| lie_op8(instr_reg) == `LIE_OP_MULT_MOVE)) begin
			accum_reg <= accum_reg + i_product; // RQ11
		end
	end

	// ------------------------------------------------------------
	// Index registers
	// ------------------------------------------------------------
	// One process per register; the selector is bit 8 of the instruction.
	for (genvar g = 0; g < 2; g++) begin : g_index
		always_ff @(posedge i_clock or negedge i_rstn) begin
			if (!i_rstn) begin
				index_reg[g] <= 16'h0000;
			end else if (state_reg == LIE_IDLE && i_instr_valid && lie_op7(i_instr) == `LIE_OP_IDX_IMM
				&& i_instr[`LIE_F_SEL] == 1'(g)) begin
				index_reg[g] <= {8'h00, i_instr[`LIE_F_CONST_MSB:`LIE_F_LOW]}; // RQ2 RQ3
			end else if (state_reg == LIE_READ && lie_op7(instr_reg) == `LIE_OP_IDX_MEM
				&& instr_reg[`LIE_F_SEL] == 1'(g)) begin
				index_reg[g] <= i_dmem_rdata; // RQ10
			end
		end
	end

	// ------------------------------------------------------------
	// Multiplicand
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mult_reg <= 16'h0000;
		end else if (state_reg == LIE_READ && (lie_op8(instr_reg) == `LIE_OP_MULT
			|| lie_op8(instr_reg) == `LIE_OP_MULT_ACC || lie_op8(instr_reg) == `LIE_OP_MULT_MOVE)) begin
			mult_reg <= i_dmem_rdata; // RQ11
		end
	end

	// ------------------------------------------------------------
	// Status bits
	// ------------------------------------------------------------
	// The mask bit follows the core's own interrupt control, never a loaded word.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			status_reg <= '0;
		end else begin
			status_reg.mask <= i_irq_mask; // RQ5
			if (state_reg == LIE_READ && lie_op8(instr_reg) == `LIE_OP_STAT_LOAD) begin
				status_reg.wrap <= i_dmem_rdata[`LIE_SW_WRAP]; // RQ4
				status_reg.sat <= i_dmem_rdata[`LIE_SW_SAT];
				status_reg.ptr <= i_dmem_rdata[`LIE_SW_PTR];
				status_reg.page <= i_dmem_rdata[`LIE_SW_PAGE];
			end else if (state_reg == LIE_READ && lie_op8(instr_reg) == `LIE_OP_PAGE_MEM) begin
				status_reg.page <= i_dmem_rdata[`LIE_F_LOW]; // RQ10
			end else if (state_reg == LIE_IDLE && i_instr_valid) begin
				if ((i_instr & `LIE_OP_PAGE_IMM_MASK) == `LIE_OP_PAGE_IMM) begin
					status_reg.page <= i_instr[`LIE_F_LOW]; // RQ10
				end
				if ((i_instr & `LIE_OP_IDX_SEL_MASK) == `LIE_OP_IDX_SEL) begin
					status_reg.ptr <= i_instr[`LIE_F_LOW];
				end
			end
			// Indirect forms may name the next pointer; a status load's own value gives way to it.
			if (state_reg == LIE_READ && instr_reg[`LIE_F_IND] && instr_reg[`LIE_F_NEXT_EN]) begin
				status_reg.ptr <= instr_reg[`LIE_F_NEXT_VAL]; // RQ9
			end
		end
	end

	// ------------------------------------------------------------
	// Data memory writes
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			dwrite_reg <= '0;
		end else begin
			dwrite_reg.we <= 1'b0;
			if (state_reg == LIE_IDLE && i_instr_valid && lie_op8(i_instr) == `LIE_OP_STAT_STORE) begin
				dwrite_reg.we <= 1'b1;
				dwrite_reg.addr <= lie_eff_addr(i_instr, `LIE_STORE_PAGE, cur_index); // RQ7
				dwrite_reg.data <= saved_word;
			end else if (state_reg == LIE_MOVE) begin
				dwrite_reg.we <= 1'b1;
				dwrite_reg.addr <= raddr_reg + `LIE_MOVE_STEP; // RQ11
				dwrite_reg.data <= mult_reg;
			end
		end
	end

	assign o_busy = (state_reg != LIE_IDLE);
	assign o_pc_inc = pc_inc_reg;
	assign o_dmem_raddr = raddr_reg;
	assign o_dmem_write = dwrite_reg;
	assign o_accum = accum_reg;
	assign o_index0 = index_reg[0];
	assign o_index1 = index_reg[1];
	assign o_multiplicand = mult_reg;
	assign o_status = status_reg;
	assign o_status_word = saved_word;
endmodule : lie_exec

// ===== test/lie_chk.sv
// Assertion checker for the load instruction execution block.
`timescale 1ns/1ns
module lie_chk
	import lie_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [15:0] i_dmem_rdata,
	input wire logic i_irq_mask,
	input wire logic o_busy,
	input wire logic o_pc_inc,
	input wire logic [7:0] o_dmem_raddr,
	input wire lie_dwrite_t o_dmem_write,
	input wire logic [31:0] o_accum,
	input wire logic [15:0] o_index0,
	input wire logic [15:0] o_index1,
	input wire logic [15:0] o_multiplicand,
	input wire lie_status_t o_status,
	input wire logic [15:0] o_status_word
);
	// ------
	// Properties
	// ------
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// An instruction counts only when the block is free to take it.
	wire take = i_instr_valid && !o_busy;
	sequence stat_take; take && i_instr[15:7] == 9'h0f6; endsequence
	sequence mult_take; take && i_instr[15:8] == 8'h6a; endsequence
	sequence move_take; take && i_instr[15:8] == 8'h6b; endsequence
	acc_imm_a: assert property (take && i_instr[15:8] == 8'h7e |=>
		o_pc_inc && o_accum == {24'h00_0000, $past(i_instr[7:0])}) else $error("accumulator load wrong");
	idx_imm_a: assert property (take && i_instr[15:9] == 7'h38 |=>
		($past(i_instr[8]) ? o_index1 : o_index0) == {8'h00, $past(i_instr[7:0])}) else $error("index load wrong");
	status_addr_a: assert property (stat_take |=>
		o_dmem_raddr == {$past(o_status.page), $past(i_instr[6:0])}) else $error("status read address wrong");
	status_load_a: assert property (stat_take ##2 1'b1 |-> o_pc_inc && o_status.wrap == $past(i_dmem_rdata[15]) &&
		o_status.sat == $past(i_dmem_rdata[14]) && o_status.ptr == $past(i_dmem_rdata[8])) else $error("status load");
	mask_keep_a: assert property (1'b1 |=> o_status.mask == $past(i_irq_mask)) else $error("mask changed");
	word_layout_a: assert property (o_status_word == {o_status.wrap, o_status.sat, o_status.mask, 4'hf,
		o_status.ptr, 6'h3f, 1'b0, o_status.page}) else $error("status layout wrong");
	store_page_a: assert property (take && i_instr[15:7] == 9'h0f8 |=> o_dmem_write.we &&
		o_dmem_write.addr == {1'b1, $past(i_instr[6:0])} && o_dmem_write.data == $past(o_status_word))
		else $error("status store page wrong");
	mult_load_a: assert property (mult_take ##2 1'b1 |-> o_multiplicand == $past(i_dmem_rdata))
		else $error("multiplicand load wrong");
	move_write_a: assert property (move_take |=> o_busy ##1 o_busy ##1 (!o_busy && o_pc_inc &&
		o_dmem_write.we && o_dmem_write.addr == o_dmem_raddr + 8'h01 && o_dmem_write.data == o_multiplicand))
		else $error("move variant write wrong");
endmodule : lie_chk

bind lie_exec lie_chk u_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
	.i_instr(i_instr), .i_dmem_rdata(i_dmem_rdata), .i_irq_mask(i_irq_mask), .o_busy(o_busy),
	.o_pc_inc(o_pc_inc), .o_dmem_raddr(o_dmem_raddr), .o_dmem_write(o_dmem_write), .o_accum(o_accum),
	.o_index0(o_index0), .o_index1(o_index1), .o_multiplicand(o_multiplicand), .o_status(o_status),
	.o_status_word(o_status_word));

// ===== test/lie_mem.sv
// Data memory model standing on the block's memory buses.
`timescale 1ns/1ns
module lie_mem
	import lie_pkg::*;
(
	input wire logic i_clock,
	input wire logic [7:0] i_raddr,
	input wire lie_dwrite_t i_write,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [256];
	// Read is asynchronous so the word is settled for the whole read cycle.
	assign o_rdata = mem[i_raddr];
	// Plain always so that the bench may preload words by hierarchy.
	always @(posedge i_clock) begin
		if (i_write.we) begin
			mem[i_write.addr] <= i_write.data;
		end
	end
endmodule : lie_mem

// ===== test/test_load_instruction_exec.sv
// Self-checking testbench for the load instruction execution block.
`timescale 1ns/1ns
module test_load_instruction_exec
	import lie_pkg::*;
;
	logic i_clock, i_rstn, i_instr_valid, i_irq_mask, o_busy, o_pc_inc;
	logic [15:0] i_instr, i_dmem_rdata, i_index_addr, o_index0, o_index1, o_multiplicand, o_status_word;
	logic [31:0] i_product, o_accum;
	logic [7:0] o_dmem_raddr;
	lie_dwrite_t o_dmem_write;
	lie_status_t o_status;
	int n_mismatch = 0;
	int tests_run = 0;
	lie_exec u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
		.i_dmem_rdata(i_dmem_rdata), .i_product(i_product), .i_index_addr(i_index_addr),
		.i_irq_mask(i_irq_mask), .o_busy(o_busy), .o_pc_inc(o_pc_inc), .o_dmem_raddr(o_dmem_raddr),
		.o_dmem_write(o_dmem_write), .o_accum(o_accum), .o_index0(o_index0), .o_index1(o_index1),
		.o_multiplicand(o_multiplicand), .o_status(o_status), .o_status_word(o_status_word));
	lie_mem u_mem (.i_clock(i_clock), .i_raddr(o_dmem_raddr), .i_write(o_dmem_write), .o_rdata(i_dmem_rdata));
	// ------
	// Shared tasks
	// ------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Present one instruction and wait, bounded, for its completion pulse.
	task automatic run(input logic [15:0] op);
		int n = 0;
		@(posedge i_clock) #1;
		i_instr_valid = 1'b1;
		i_instr = op;
		@(posedge i_clock) #1;
		i_instr_valid = 1'b0;
		while (o_pc_inc !== 1'b1 && n < 4) begin
			@(posedge i_clock) #1;
			n++;
		end
		chk({31'h0, o_pc_inc}, 32'h0000_0001);
	endtask : run
	task automatic t_immediate();
		run(16'h7eff);
		chk(o_accum, 32'h0000_00ff);
		run(16'h7080);
		chk({16'h0, o_index0}, 32'h0000_0080);
		run(16'h71ff);
		chk({16'h0, o_index1}, 32'h0000_00ff);
	endtask : t_immediate
	// Status load from page 1 with the mask bit set in memory, then a store from page 0.
	task automatic t_status();
		u_mem.mem[8'h85] = 16'hffff;
		run(16'h6e01);
		run(16'h7b05);
		chk({16'h0, o_status_word}, 32'h0000_dffd);
		run(16'h6e00);
		run(16'h7c10);
		@(posedge i_clock) #1;
		chk({16'h0, u_mem.mem[8'h90]}, 32'h0000_dffc);
	endtask : t_status
	task automatic t_mult();
		u_mem.mem[8'h20] = 16'h1234;
		u_mem.mem[8'h21] = 16'h0002;
		u_mem.mem[8'h22] = 16'habcd;
		i_product = 32'h0000_0010;
		i_irq_mask = 1'b1;
		run(16'h6a20);
		chk({16'h0, o_multiplicand}, 32'h0000_1234);
		run(16'h6c21);
		chk(o_accum, 32'h0000_010f);
		run(16'h6b22);
		@(posedge i_clock) #1;
		chk({16'h0, u_mem.mem[8'h23]}, 32'h0000_abcd);
		chk(o_accum, 32'h0000_011f);
		run(16'h3822);
		chk({16'h0, o_index0}, 32'h0000_abcd);
	endtask : t_mult
	// Pointer steering: select, indirect page load naming a next pointer, indirect status load.
	task automatic t_pointer();
		u_mem.mem[8'h30] = 16'h0001;
		u_mem.mem[8'h44] = 16'h0000;
		run(16'h7030);
		run(16'h7144);
		run(16'h6880);
		run(16'h6f89);
		chk({31'h0, o_status.page}, 32'h0000_0001);
		chk({31'h0, o_status.ptr}, 32'h0000_0001);
		run(16'h7b80);
		chk({16'h0, o_status_word}, 32'h0000_3efc);
	endtask : t_pointer
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// Clock of 100 ns period.
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	// Watchdog at 2000 cycles, far beyond the fewer than one hundred cycles the tests need.
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
	// Main sequence: reset for 12 cycles, then the scenarios.
	initial begin
		i_rstn = 1'b0;
		i_instr_valid = 1'b0;
		i_instr = 16'h0000;
		i_product = 32'h0000_0000;
		i_index_addr = 16'h0000;
		i_irq_mask = 1'b0;
		repeat (12) @(posedge i_clock);
		#1 i_rstn = 1'b1;
		t_immediate();
		t_status();
		t_mult();
		t_pointer();
		end_sim();
	end
endmodule : test_load_instruction_exec
